// ===== rtl/cfs_pkg.sv
/*
 * Shared constants and types for the CPU frequency source selector.
 * Assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */
package cfs_pkg;

  // Register byte offsets
  localparam logic [7:0] CFS_OFF_CTRL = 8'h00;
  localparam logic [7:0] CFS_OFF_CPU_NUM = 8'h04;
  localparam logic [7:0] CFS_OFF_CPU_DEN = 8'h08;
  localparam logic [7:0] CFS_OFF_CPU_PAIR = 8'h0C;
  localparam logic [7:0] CFS_OFF_RCV_PAIR = 8'h10;
  localparam logic [7:0] CFS_OFF_STATUS = 8'h14;

  // Control register fields
  localparam int CFS_CTRL_PROG_EN = 0;
  localparam int CFS_CTRL_OVERRIDE = 1;
  localparam int CFS_CTRL_RCV_SEL = 2;
  localparam int CFS_CTRL_SEL_LSB = 4;

  // Pair register fields
  localparam int CFS_PAIR_NUM_LSB = 0;
  localparam int CFS_PAIR_DEN_LSB = 8;

  // Status register fields
  localparam int CFS_STAT_STRAP_LSB = 0;
  localparam int CFS_STAT_STRAP_OK = 5;
  localparam int CFS_STAT_RCV_ACT = 6;
  localparam int CFS_STAT_PROG = 7;
  localparam int CFS_STAT_SEL_LSB = 8;

  // Field widths
  localparam int CFS_SEL_W = 5;
  localparam int CFS_NUM_W = 8;
  localparam int CFS_DEN_W = 7;

  // Reset values
  localparam logic CFS_RST_PROG_EN = 1'b0;
  localparam logic CFS_RST_OVERRIDE = 1'b0;
  localparam logic CFS_RST_RCV_SEL = 1'b0;
  localparam logic [4:0] CFS_RST_SEL = 5'h00;
  localparam logic [7:0] CFS_RST_NUM = 8'h00;
  localparam logic [6:0] CFS_RST_DEN = 7'h00;

  // Strap settle time after reset release
  localparam int CFS_STRAP_SETTLE_NS = 64;
  localparam int CFS_CLK_PERIOD_NS = 8;
  localparam int CFS_STRAP_SETTLE_CYC =
    (CFS_STRAP_SETTLE_NS + CFS_CLK_PERIOD_NS - 1) / CFS_CLK_PERIOD_NS;

  // AHB encodings
  localparam logic [1:0] CFS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] CFS_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [6:0] den;
    logic [7:0] num;
  } cfs_ratio_t;

  typedef enum logic [1:0] {
    CFS_STRAP_SETTLE,
    CFS_STRAP_HELD
  } cfs_strap_state_t;

endpackage

// ===== rtl/cfs_top.sv
/*
 * CPU frequency source selector with an AHB-Lite register slave.
 * Picks the gear/ratio select, the numerator/denominator pair and the mode
 * driven to the PLL, from straps, software bits or recovery values.
 * Assumes straps are asynchronous pins and the watchdog timeout pulse comes
 * from logic on clk_in.
 */
// Contract
// - Programmable enable clears at reset
// - Disabled mode: straps or software select
// - Override resets zero, selects straps
// - Enabled mode: programmed numerator/denominator drive CPU
// - Enabled, override clear: straps give gear
// - Enabled, override set: software gives gear
// - Numerator or denominator write starts load (the code drops it before the straps settle while override is clear)
// - Recovery pair with latched strap ratio
// - Timeout switches to selected recovery source
`timescale 1ns/10ps
module cfs_top #(
  parameter int STRAP_SETTLE_CYC = cfs_pkg::CFS_STRAP_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Straps and watchdog
  input wire logic [4:0] strap_frequency_select_in,
  input wire logic watchdog_timeout_in,
  // PLL control
  output logic prog_mode_out,
  output logic [4:0] gear_select_out,
  output logic [7:0] freq_numerator_out,
  output logic [6:0] freq_denominator_out,
  output logic freq_load_out,
  output logic recovery_active_out
);

  // Two synchroniser stages must fill before the strap capture
  if (STRAP_SETTLE_CYC < 2 || STRAP_SETTLE_CYC > 255) begin : gen_bad_settle
    $error("STRAP_SETTLE_CYC out of range");
  end
  // Field widths must match the PLL control ports
  if (cfs_pkg::CFS_SEL_W != $bits(gear_select_out) ||
      cfs_pkg::CFS_NUM_W != $bits(freq_numerator_out) ||
      cfs_pkg::CFS_DEN_W != $bits(freq_denominator_out)) begin : gen_bad_width
    $error("field widths do not match the PLL ports");
  end
  // Numerator and denominator must not overlap in a pair word
  if (cfs_pkg::CFS_PAIR_DEN_LSB <
      cfs_pkg::CFS_PAIR_NUM_LSB + cfs_pkg::CFS_NUM_W) begin : gen_bad_pair
    $error("pair fields overlap");
  end
  // Select fields must fit in a bus word
  if (cfs_pkg::CFS_CTRL_SEL_LSB + cfs_pkg::CFS_SEL_W > $bits(hrdata_out) ||
      cfs_pkg::CFS_STAT_SEL_LSB + cfs_pkg::CFS_SEL_W > $bits(hrdata_out)) begin : gen_bad_fit
    $error("select fields exceed the bus word");
  end
  // Every register sits on its own aligned word
  if ((cfs_pkg::CFS_OFF_CTRL[1:0] | cfs_pkg::CFS_OFF_CPU_NUM[1:0] |
       cfs_pkg::CFS_OFF_CPU_DEN[1:0] | cfs_pkg::CFS_OFF_CPU_PAIR[1:0] |
       cfs_pkg::CFS_OFF_RCV_PAIR[1:0] | cfs_pkg::CFS_OFF_STATUS[1:0]) !=
      2'h0) begin : gen_bad_align
    $error("register offsets must be word aligned");
  end

  function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
    is_off = (a == off);
  endfunction

  // Strap synchroniser and latch
  logic [4:0] strap_s1_r;
  logic [4:0] strap_s2_r;
  logic [4:0] strap_latched_r, strap_latched_nxt;
  logic [7:0] settle_cnt_r, settle_cnt_nxt;
  cfs_pkg::cfs_strap_state_t strap_st_r, strap_st_nxt;

  always_comb begin
    strap_latched_nxt = strap_latched_r;
    settle_cnt_nxt = settle_cnt_r;
    strap_st_nxt = strap_st_r;
    case (strap_st_r)
      cfs_pkg::CFS_STRAP_SETTLE: begin
        if (settle_cnt_r >= 8'(STRAP_SETTLE_CYC)) begin
          // Counting from release lets both synchroniser stages fill first
          strap_latched_nxt = strap_s2_r;
          strap_st_nxt = cfs_pkg::CFS_STRAP_HELD;
        end else begin
          settle_cnt_nxt = settle_cnt_r + 8'h01;
        end
      end
      default: begin
        strap_st_nxt = cfs_pkg::CFS_STRAP_HELD;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_s1_r <= 5'h00;
      strap_s2_r <= 5'h00;
      strap_latched_r <= 5'h00;
      settle_cnt_r <= 8'h00;
      strap_st_r <= cfs_pkg::CFS_STRAP_SETTLE;
    end else begin
      strap_s1_r <= strap_frequency_select_in;
      strap_s2_r <= strap_s1_r;
      strap_latched_r <= strap_latched_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      strap_st_r <= strap_st_nxt;
    end
  end

  logic strap_ok;
  assign strap_ok = (strap_st_r == cfs_pkg::CFS_STRAP_HELD);

  // Bus and register state
  logic dp_wr_r, dp_wr_nxt;
  logic [7:0] dp_addr_r, dp_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic prog_en_r, prog_en_nxt;
  logic override_r, override_nxt;
  logic rcv_sel_r, rcv_sel_nxt;
  logic [4:0] soft_sel_r, soft_sel_nxt;
  cfs_pkg::cfs_ratio_t cpu_r, cpu_nxt;
  cfs_pkg::cfs_ratio_t rcv_r, rcv_nxt;
  logic rcv_act_r, rcv_act_nxt;
  logic load_r, load_nxt;
  logic prog_r, prog_nxt;
  logic [4:0] gear_r, gear_nxt;
  logic [7:0] num_r, num_nxt;
  logic [6:0] den_r, den_nxt;
  logic hreadyout_r, hreadyout_nxt;
  logic hresp_r, hresp_nxt;
  logic addr_phase;
  logic [31:0] wd;

  assign addr_phase = hsel_in && hready_in && htrans_in[1];
  assign wd = hwdata_in;

  always_comb begin
    dp_wr_nxt = 1'b0;
    dp_addr_nxt = dp_addr_r;
    prog_en_nxt = prog_en_r;
    override_nxt = override_r;
    rcv_sel_nxt = rcv_sel_r;
    soft_sel_nxt = soft_sel_r;
    cpu_nxt = cpu_r;
    rcv_nxt = rcv_r;
    rcv_act_nxt = rcv_act_r;
    load_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    hreadyout_nxt = 1'b1;
    hresp_nxt = 1'b0;

    // Write data phase
    if (dp_wr_r) begin
      if (is_off(dp_addr_r, cfs_pkg::CFS_OFF_CTRL)) begin
        prog_en_nxt = wd[cfs_pkg::CFS_CTRL_PROG_EN];
        override_nxt = wd[cfs_pkg::CFS_CTRL_OVERRIDE];
        rcv_sel_nxt = wd[cfs_pkg::CFS_CTRL_RCV_SEL];
        soft_sel_nxt = wd[cfs_pkg::CFS_CTRL_SEL_LSB +: cfs_pkg::CFS_SEL_W];
      end else if (is_off(dp_addr_r, cfs_pkg::CFS_OFF_CPU_NUM)) begin
        cpu_nxt.num = wd[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_NUM_W];
        load_nxt = 1'b1;
      end else if (is_off(dp_addr_r, cfs_pkg::CFS_OFF_CPU_DEN)) begin
        cpu_nxt.den = wd[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_DEN_W];
        load_nxt = 1'b1;
      end else if (is_off(dp_addr_r, cfs_pkg::CFS_OFF_CPU_PAIR)) begin
        // Both fields in one transfer avoid an intermediate frequency
        cpu_nxt.num = wd[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_NUM_W];
        cpu_nxt.den = wd[cfs_pkg::CFS_PAIR_DEN_LSB +: cfs_pkg::CFS_DEN_W];
        load_nxt = 1'b1;
      end else if (is_off(dp_addr_r, cfs_pkg::CFS_OFF_RCV_PAIR)) begin
        rcv_nxt.num = wd[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_NUM_W];
        rcv_nxt.den = wd[cfs_pkg::CFS_PAIR_DEN_LSB +: cfs_pkg::CFS_DEN_W];
      end else if (is_off(dp_addr_r, cfs_pkg::CFS_OFF_STATUS)) begin
        if (wd[cfs_pkg::CFS_STAT_RCV_ACT]) begin
          rcv_act_nxt = 1'b0;
        end
      end
    end

    // Timeout wins over a clear in the same cycle
    if (watchdog_timeout_in) begin
      rcv_act_nxt = 1'b1;
      load_nxt = 1'b1;
    end

    // Source selection
    if (rcv_act_nxt) begin
      gear_nxt = strap_latched_r;
      prog_nxt = rcv_sel_nxt;
      num_nxt = rcv_sel_nxt ? rcv_nxt.num : cpu_r.num;
      den_nxt = rcv_sel_nxt ? rcv_nxt.den : cpu_r.den;
    end else begin
      prog_nxt = prog_en_nxt;
      // Override picks the same source for gear in both modes
      gear_nxt = override_nxt ? soft_sel_nxt : strap_latched_r;
      num_nxt = cpu_nxt.num;
      den_nxt = cpu_nxt.den;
    end
    // A load before the straps settle would steer the PLL from reset values
    if (!strap_ok && !override_nxt) begin
      load_nxt = 1'b0;
    end

    // Address phase, read data built from next values
    if (addr_phase) begin
      dp_wr_nxt = hwrite_in;
      dp_addr_nxt = haddr_in[7:0];
      if (!hwrite_in) begin
        if (is_off(haddr_in[7:0], cfs_pkg::CFS_OFF_CTRL)) begin
          rdata_nxt[cfs_pkg::CFS_CTRL_PROG_EN] = prog_en_nxt;
          rdata_nxt[cfs_pkg::CFS_CTRL_OVERRIDE] = override_nxt;
          rdata_nxt[cfs_pkg::CFS_CTRL_RCV_SEL] = rcv_sel_nxt;
          rdata_nxt[cfs_pkg::CFS_CTRL_SEL_LSB +: cfs_pkg::CFS_SEL_W] = soft_sel_nxt;
        end else if (is_off(haddr_in[7:0], cfs_pkg::CFS_OFF_CPU_NUM)) begin
          rdata_nxt[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_NUM_W] = cpu_nxt.num;
        end else if (is_off(haddr_in[7:0], cfs_pkg::CFS_OFF_CPU_DEN)) begin
          rdata_nxt[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_DEN_W] = cpu_nxt.den;
        end else if (is_off(haddr_in[7:0], cfs_pkg::CFS_OFF_CPU_PAIR)) begin
          rdata_nxt[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_NUM_W] = cpu_nxt.num;
          rdata_nxt[cfs_pkg::CFS_PAIR_DEN_LSB +: cfs_pkg::CFS_DEN_W] = cpu_nxt.den;
        end else if (is_off(haddr_in[7:0], cfs_pkg::CFS_OFF_RCV_PAIR)) begin
          rdata_nxt[cfs_pkg::CFS_PAIR_NUM_LSB +: cfs_pkg::CFS_NUM_W] = rcv_nxt.num;
          rdata_nxt[cfs_pkg::CFS_PAIR_DEN_LSB +: cfs_pkg::CFS_DEN_W] = rcv_nxt.den;
        end else if (is_off(haddr_in[7:0], cfs_pkg::CFS_OFF_STATUS)) begin
          rdata_nxt[cfs_pkg::CFS_STAT_STRAP_LSB +: cfs_pkg::CFS_SEL_W] = strap_latched_nxt;
          rdata_nxt[cfs_pkg::CFS_STAT_STRAP_OK] =
            (strap_st_nxt == cfs_pkg::CFS_STRAP_HELD);
          rdata_nxt[cfs_pkg::CFS_STAT_RCV_ACT] = rcv_act_nxt;
          rdata_nxt[cfs_pkg::CFS_STAT_PROG] = prog_nxt;
          rdata_nxt[cfs_pkg::CFS_STAT_SEL_LSB +: cfs_pkg::CFS_SEL_W] = gear_nxt;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
      prog_en_r <= cfs_pkg::CFS_RST_PROG_EN;
      override_r <= cfs_pkg::CFS_RST_OVERRIDE;
      rcv_sel_r <= cfs_pkg::CFS_RST_RCV_SEL;
      soft_sel_r <= cfs_pkg::CFS_RST_SEL;
      cpu_r <= {cfs_pkg::CFS_RST_DEN, cfs_pkg::CFS_RST_NUM};
      rcv_r <= {cfs_pkg::CFS_RST_DEN, cfs_pkg::CFS_RST_NUM};
      rcv_act_r <= 1'b0;
      load_r <= 1'b0;
      prog_r <= cfs_pkg::CFS_RST_PROG_EN;
      gear_r <= 5'h00;
      num_r <= cfs_pkg::CFS_RST_NUM;
      den_r <= cfs_pkg::CFS_RST_DEN;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      dp_wr_r <= dp_wr_nxt;
      dp_addr_r <= dp_addr_nxt;
      rdata_r <= rdata_nxt;
      prog_en_r <= prog_en_nxt;
      override_r <= override_nxt;
      rcv_sel_r <= rcv_sel_nxt;
      soft_sel_r <= soft_sel_nxt;
      cpu_r <= cpu_nxt;
      rcv_r <= rcv_nxt;
      rcv_act_r <= rcv_act_nxt;
      load_r <= load_nxt;
      prog_r <= prog_nxt;
      gear_r <= gear_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
      hreadyout_r <= hreadyout_nxt;
      hresp_r <= hresp_nxt;
    end
  end

  // Zero-wait slave, always OKAY, still taken from flops
  assign hreadyout_out = hreadyout_r;
  assign hresp_out = hresp_r;
  assign hrdata_out = rdata_r;
  assign prog_mode_out = prog_r;
  assign gear_select_out = gear_r;
  assign freq_numerator_out = num_r;
  assign freq_denominator_out = den_r;
  assign freq_load_out = load_r;
  assign recovery_active_out = rcv_act_r;

endmodule

// ===== verif/cfs_host.sv
/* AHB-Lite host model issuing single word transfers.
   Assumes the caller enters its task right after a rising edge. */
`timescale 1ns/10ps
module cfs_host (
  // Bus
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out = 1'b0,
  output logic [31:0] haddr_out = 32'h0,
  output logic [1:0] htrans_out = 2'h0,
  output logic hwrite_out = 1'b0,
  output logic [2:0] hsize_out = 3'h2,
  output logic [31:0] hwdata_out = 32'h0
);
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output bit ok);
    int n = 0;
    hsel_out <= 1'b1;
    haddr_out <= {24'h0, a};
    htrans_out <= cfs_pkg::CFS_HTRANS_NONSEQ;
    hwrite_out <= w;
    hsize_out <= cfs_pkg::CFS_HSIZE_WORD;
    do begin
      @(posedge clk_in);
      n++;
    end while (!hready_in && n < 50);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    haddr_out <= ~{24'h0, a};
    hwdata_out <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (!hready_in && n < 100);
    r = hrdata_in;
    ok = hready_in;
  endtask
endmodule

// ===== verif/cfs_props.sv
/* Port checker for the frequency source selector.
   Assumes one clock and single AHB-Lite transfers. */
`timescale 1ns/10ps
module cfs_props #(
  parameter int STRAP_SETTLE_CYC = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  // Control
  input wire logic watchdog_timeout_in,
  input wire logic prog_mode_out,
  input wire logic [4:0] gear_select_out,
  input wire logic freq_load_out,
  input wire logic recovery_active_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic wr;
  logic rd;
  logic settled;
  logic [2:0] cause_r;
  logic [2:0] cause_nxt;
  logic [3:0] age_r;
  logic [3:0] age_nxt;
  assign wr = hsel_in && htrans_in[1] && hwrite_in;
  assign rd = hsel_in && htrans_in[1] && !hwrite_in;
  assign settled = age_r > 4'(STRAP_SETTLE_CYC + 3);
  always_comb begin
    cause_nxt = {cause_r[1:0], wr || watchdog_timeout_in};
    age_nxt = (age_r == 4'hF) ? age_r : age_r + 4'h1;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cause_r <= 3'h0;
      age_r <= 4'h0;
    end else begin
      cause_r <= cause_nxt;
      age_r <= age_nxt;
    end
  end
  sequence s_num_wr;
    wr && settled && !recovery_active_out && (haddr_in[7:0] inside {8'h04, 8'h08, 8'h0C})
      ##1 1'b1;
  endsequence
  property p_reset_idle; $rose(resetn_in) |-> !prog_mode_out && !recovery_active_out; endproperty
  property p_bus_okay; 1'b1 |-> hreadyout_out && !hresp_out; endproperty
  property p_rd_data; hrdata_out != 32'h0 |-> $past(rd); endproperty
  property p_num_load; s_num_wr |-> ##[0:2] freq_load_out; endproperty
  property p_load_cause; settled && freq_load_out |-> |cause_r; endproperty
  property p_gear_hold; settled && !(|cause_r[1:0]) |-> $stable(gear_select_out); endproperty
  property p_wd_switch; watchdog_timeout_in |-> ##[1:2] recovery_active_out; endproperty
  property p_rcv_hold;
    recovery_active_out && !wr && !cause_r[0] |=> recovery_active_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
  a_rd_data: assert property (p_rd_data) else $error("read data without read");
  a_num_load: assert property (p_num_load) else $error("no load after ratio write");
  a_load_cause: assert property (p_load_cause) else $error("load without cause");
  a_gear_hold: assert property (p_gear_hold) else $error("gear moved by itself");
  a_wd_switch: assert property (p_wd_switch) else $error("timeout ignored");
  a_rcv_hold: assert property (p_rcv_hold) else $error("recovery dropped");
endmodule
bind cfs_top cfs_props #(.STRAP_SETTLE_CYC(STRAP_SETTLE_CYC)) props_u (.clk_in, .resetn_in,
  .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hreadyout_out, .hresp_out, .hrdata_out,
  .watchdog_timeout_in, .prog_mode_out, .gear_select_out, .freq_load_out,
  .recovery_active_out);

// ===== verif/tb_cpu_freq_source_select.sv
/* Self-checking bench for the frequency source selector.
   Assumes the host model drives the bus; straps are inverted once after the first latch. */
`timescale 1ns/10ps
module tb_cpu_freq_source_select;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic wdt = 1'b0;
  logic [4:0] strap = 5'h00;
  logic hsel, hwrite, hrdy, hresp, prog, load, rcv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [4:0] gear, s, sel;
  logic [7:0] num, n;
  logic [6:0] den, d;
  logic ov, pe;
  int err_total = 0;
  int num_checks = 0;
  initial forever #4 clk_in = ~clk_in;
  cfs_host host_u (.clk_in, .hready_in(hrdy), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));
  cfs_top #(.STRAP_SETTLE_CYC(2)) dut_u (.clk_in, .resetn_in, .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
    .hrdata_out(hrdata), .strap_frequency_select_in(strap), .watchdog_timeout_in(wdt),
    .prog_mode_out(prog), .gear_select_out(gear), .freq_numerator_out(num),
    .freq_denominator_out(den), .freq_load_out(load), .recovery_active_out(rcv));
  task automatic summarize;
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    bit ok;
    host_u.xfer(a, w, wd, r, ok);
    if (!ok) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic wait_load;
    bit hit = 0;
    repeat (3) begin
      @(posedge clk_in);
      if (load === 1'b1) hit = 1;
    end
    chk(32'(hit), 32'h1);
  endtask
  task automatic pulse_wd;
    wdt <= 1'b1;
    @(posedge clk_in);
    wdt <= 1'b0;
    wait_load();
  endtask
  function automatic logic [4:0] exp_gear(input logic o, input logic [4:0] sl);
    return o ? sl : s;
  endfunction
  initial begin
    void'($urandom(32'h43CC7647));
    strap = 5'($urandom);
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    s = strap;
    strap <= ~strap;
    bus(cfs_pkg::CFS_OFF_STATUS, 1'b0, 32'h0);
    chk(r[5:0], {1'b1, s});
    bus(cfs_pkg::CFS_OFF_CTRL, 1'b0, 32'h0);
    chk(r, 32'h0);
    chk({prog, gear}, {1'b0, s});
    bus(8'h1C, 1'b0, 32'h0);
    chk(r, 32'h0);
    repeat (8) begin
      {ov, pe, sel, n, d} = 22'($urandom);
      bus(cfs_pkg::CFS_OFF_CTRL, 1'b1, {23'h0, sel, 2'h0, ov, pe});
      bus(cfs_pkg::CFS_OFF_CPU_PAIR, 1'b1, {17'h0, d, n});
      wait_load();
      chk({prog, gear}, {pe, exp_gear(ov, sel)});
      if (pe) chk({num, den}, {n, d});
    end
    bus(cfs_pkg::CFS_OFF_CTRL, 1'b1, 32'h1);
    bus(cfs_pkg::CFS_OFF_CPU_NUM, 1'b1, 32'h5A);
    wait_load();
    bus(cfs_pkg::CFS_OFF_CPU_DEN, 1'b1, 32'h33);
    wait_load();
    chk({num, den}, {8'h5A, 7'h33});
    {sel, n, d} = 20'($urandom);
    bus(cfs_pkg::CFS_OFF_RCV_PAIR, 1'b1, {17'h0, d, n});
    bus(cfs_pkg::CFS_OFF_CTRL, 1'b1, {23'h0, sel, 4'h7});
    pulse_wd();
    chk({rcv, prog, gear, num, den}, {2'h3, s, n, d});
    bus(cfs_pkg::CFS_OFF_STATUS, 1'b1, 32'h40);
    @(posedge clk_in);
    chk(32'(rcv), 32'h0);
    bus(cfs_pkg::CFS_OFF_CTRL, 1'b1, 32'h0);
    pulse_wd();
    chk({rcv, prog, gear}, {2'h2, s});
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    bus(cfs_pkg::CFS_OFF_CTRL, 1'b0, 32'h0);
    chk(r, 32'h0);
    chk({rcv, prog, gear}, {2'h0, ~s});
    summarize();
  end
endmodule
